/* owdt_cfg.svh */
// Constants for the one-time watchdog
`ifndef OWDT_CFG_SVH
`define OWDT_CFG_SVH
`define OWDT_KEY_ADDR      8'ha6
`define OWDT_KEY_FIRST     8'h1e
`define OWDT_KEY_SECOND    8'he1
`define OWDT_CNT_WIDTH     14
`define OWDT_CNT_TOP       14'h3fff
`define OWDT_CNT_RESET     14'h0000
`define OWDT_MC_DIV        12
`define OWDT_PULSE_OSC     98
`define OWDT_OSC_PER_CLK   1
`define OWDT_PULSE_CYC     ((`OWDT_PULSE_OSC + `OWDT_OSC_PER_CLK - 1) / `OWDT_OSC_PER_CLK)
`endif

/* owdt_pkg.sv */
// Types for the one-time watchdog
package owdt_pkg;
  typedef enum logic [1:0] {
    OWDT_IDLE_KEY = 2'b00,
    OWDT_GOT_FIRST = 2'b01
  } owdt_key_t;
  typedef enum logic [1:0] {
    OWDT_OFF   = 2'b00,
    OWDT_ARMED = 2'b01,
    OWDT_FIRE  = 2'b11
  } owdt_state_t;
endpackage : owdt_pkg

/* owdt_if.sv */
// Carrier between key decoder and watchdog core
`timescale 1ns/1ns
interface owdt_if;
  logic key_done;
  modport decoder (output key_done);
  modport core    (input key_done);
endinterface : owdt_if

/* owdt_key.sv */
// Key sequence decoder for the service register
`timescale 1ns/1ns
`include "owdt_cfg.svh"
module owdt_key (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Register write port
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  // Sequence result
  owdt_if.decoder   kif
);
  import owdt_pkg::*;
  owdt_key_t key_state;
  owdt_key_t next_key_state;
  logic      done;
  logic      next_done;
  logic      hit;

  assign hit = sfr_wr && (sfr_addr == `OWDT_KEY_ADDR);
  assign kif.key_done = done;

  always_comb begin
    next_key_state = key_state;
    next_done      = 1'b0;
    if (hit) begin
      if (sfr_wdata == `OWDT_KEY_FIRST) begin
        next_key_state = OWDT_GOT_FIRST;
      end else if (sfr_wdata == `OWDT_KEY_SECOND && key_state == OWDT_GOT_FIRST) begin
        next_done      = 1'b1; // R02 R06 R15
        next_key_state = OWDT_IDLE_KEY;
      end else begin
        next_key_state = OWDT_IDLE_KEY; // R15
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key_state <= OWDT_IDLE_KEY;
      done      <= 1'b0;
    end else begin
      key_state <= next_key_state;
      done      <= next_done;
    end
  end

  a_key_pair_done: assert property (@(posedge clk) disable iff (rst) // R15
    hit && sfr_wdata == `OWDT_KEY_SECOND && key_state == OWDT_GOT_FIRST |=> done)
    else $error("key pair did not complete");
  a_key_lone_second: assert property (@(posedge clk) disable iff (rst) // R15
    hit && key_state == OWDT_IDLE_KEY |=> !done)
    else $error("lone second key accepted");
endmodule : owdt_key

/* owdt_core.sv */
// One-time watchdog with reset-out pulse
`timescale 1ns/1ns
`include "owdt_cfg.svh"
// Contract
// R01: After reset the watchdog stays disabled and does not count until armed.
// R02: Writing 1E then E1 to key register A6 arms the watchdog.
// R03: Armed counter, 14 bits, increments once each machine cycle while oscillator runs.
// R04: No software action disarms it; only hardware or overflow reset.
// R05: Counter reaching 3FFF overflows and resets the device.
// R06: Software services by the same pair at least every 16383 cycles.
// R07: Key register is write-only; counter neither readable nor writable.
// R08: Overflow drives reset pin high for 98 oscillator periods.
// R09: In power-down the counter stops and needs no service.
// R10: After power-down wake by interrupt, hold count while interrupt pin low.
// R11: Idle-hold at zero: armed watchdog keeps counting in idle.
// R12: Idle-hold set: count pauses in idle and resumes from held value.
// R13: Software should service just before entering power-down.
// R14: Software should service inside the power-down wake interrupt handler.
// R15: Sequence accepted only when E1 directly follows 1E; others cancel it.
// R16: Service clears counter; overflow returns watchdog to disabled state.
module owdt_core #(
  parameter int CNT_WIDTH = `OWDT_CNT_WIDTH,
  parameter int MC_DIV    = `OWDT_MC_DIV,
  parameter int PULSE_CYC = `OWDT_PULSE_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Register write port, no read path
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  // Power modes
  input  wire logic       idle_mode,
  input  wire logic       power_down,
  input  wire logic       wake_int_low,
  input  wire logic       idle_count_hold,
  // Reset-out pin and armed flag
  output logic            rst_pin_o,
  output logic            rst_pin_oe,
  output logic            wdt_armed
);
  import owdt_pkg::*;

  // ----------------------------------------
  // Key decoder
  // ----------------------------------------
  owdt_if kif ();
  owdt_key owdt_key_i (
    .clk       (clk),
    .rst       (rst),
    .sfr_wr    (sfr_wr),
    .sfr_addr  (sfr_addr),
    .sfr_wdata (sfr_wdata), // R07
    .kif       (kif)
  );

  // ----------------------------------------
  // Machine cycle divider
  // ----------------------------------------
  logic [7:0] div;
  logic [7:0] next_div;
  logic       mc_tick;
  logic       next_mc_tick;
  logic       osc_run;
  logic       pd_hold;
  logic       next_pd_hold;

  assign osc_run = !power_down; // R09

  always_comb begin
    next_div     = div;
    next_mc_tick = 1'b0;
    if (osc_run) begin
      if (div == 8'(MC_DIV - 1)) begin
        next_div     = 8'h00;
        next_mc_tick = 1'b1;
      end else begin
        next_div = div + 8'h01;
      end
    end
  end

  // Held after power-down until wake pin goes high
  always_comb begin
    next_pd_hold = pd_hold;
    if (power_down) next_pd_hold = 1'b1;
    else if (!wake_int_low) next_pd_hold = 1'b0; // R10
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div     <= 8'h00;
      mc_tick <= 1'b0;
      pd_hold <= 1'b0;
    end else begin
      div     <= next_div;
      mc_tick <= next_mc_tick;
      pd_hold <= next_pd_hold;
    end
  end

  // ----------------------------------------
  // Watchdog state and counter
  // ----------------------------------------
  owdt_state_t          state;
  owdt_state_t          next_state;
  logic [CNT_WIDTH-1:0] cnt;
  logic [CNT_WIDTH-1:0] next_cnt;
  logic [7:0]           pulse;
  logic [7:0]           next_pulse;
  logic                 next_pin;
  logic                 count_en;

  assign count_en = mc_tick && !power_down && !pd_hold      // R03 R09 R10
                 && !(idle_mode && idle_count_hold);        // R11 R12

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_pulse = pulse;
    next_pin   = 1'b0;
    unique case (state)
      OWDT_OFF: begin
        next_cnt = CNT_WIDTH'(`OWDT_CNT_RESET); // R01
        if (kif.key_done) next_state = OWDT_ARMED; // R02
      end
      OWDT_ARMED: begin
        if (kif.key_done) begin
          next_cnt = CNT_WIDTH'(`OWDT_CNT_RESET); // R06 R16
        end else if (count_en) begin
          if (cnt == CNT_WIDTH'(`OWDT_CNT_TOP)) begin
            next_state = OWDT_FIRE; // R05
            next_pulse = 8'(PULSE_CYC - 1);
            next_pin   = 1'b1; // R08
          end else begin
            next_cnt = cnt + 1'b1; // R03
          end
        end
      end
      OWDT_FIRE: begin
        next_pin = 1'b1; // R08
        if (pulse == 8'h00) begin
          next_pin   = 1'b0;
          next_state = OWDT_OFF; // R16
          next_cnt   = CNT_WIDTH'(`OWDT_CNT_RESET);
        end else begin
          next_pulse = pulse - 8'h01;
        end
      end
      default: next_state = OWDT_OFF;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state      <= OWDT_OFF; // R01 R04
      cnt        <= CNT_WIDTH'(`OWDT_CNT_RESET);
      pulse      <= 8'h00;
      rst_pin_o  <= 1'b0;
      rst_pin_oe <= 1'b0;
      wdt_armed  <= 1'b0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      pulse      <= next_pulse;
      rst_pin_o  <= next_pin;
      rst_pin_oe <= next_pin;
      wdt_armed  <= (next_state == OWDT_ARMED);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_fire_start;
    state == OWDT_ARMED && count_en && cnt == CNT_WIDTH'(`OWDT_CNT_TOP) && !kif.key_done;
  endsequence
  sequence s_pulse_run;
    rst_pin_o [*8];
  endsequence

  a_off_no_count: assert property (@(posedge clk) disable iff (rst) // R01
    state == OWDT_OFF |=> cnt == `OWDT_CNT_RESET)
    else $error("counter moved while disabled");
  a_arm_on_key: assert property (@(posedge clk) disable iff (rst) // R02
    state == OWDT_OFF && kif.key_done |=> state == OWDT_ARMED)
    else $error("key pair did not arm");
  a_count_step: assert property (@(posedge clk) disable iff (rst) // R03
    state == OWDT_ARMED && count_en && !kif.key_done && cnt != CNT_WIDTH'(`OWDT_CNT_TOP)
    |=> cnt == $past(cnt) + 1'b1)
    else $error("counter did not step");
  a_no_disarm: assert property (@(posedge clk) disable iff (rst) // R04
    state == OWDT_ARMED && !count_en |=> state == OWDT_ARMED)
    else $error("watchdog left armed state");
  a_overflow_pin: assert property (@(posedge clk) disable iff (rst) // R05
    s_fire_start |=> rst_pin_o && rst_pin_oe ##0 s_pulse_run)
    else $error("overflow did not drive reset");
  a_service_clr: assert property (@(posedge clk) disable iff (rst) // R06
    state == OWDT_ARMED && kif.key_done |=> cnt == `OWDT_CNT_RESET)
    else $error("service did not clear counter");
  a_pd_stop: assert property (@(posedge clk) disable iff (rst) // R09
    power_down && state == OWDT_ARMED && !kif.key_done |=> $stable(cnt))
    else $error("counter moved in power-down");
  a_wake_hold: assert property (@(posedge clk) disable iff (rst) // R10
    pd_hold && wake_int_low && !kif.key_done && state == OWDT_ARMED |=> $stable(cnt))
    else $error("counter moved during wake hold");
  a_idle_hold: assert property (@(posedge clk) disable iff (rst) // R12
    idle_mode && idle_count_hold && !kif.key_done && state == OWDT_ARMED
    |=> $stable(cnt))
    else $error("counter moved in held idle");
  a_idle_run: assert property (@(posedge clk) disable iff (rst) // R11
    idle_mode && !idle_count_hold && state == OWDT_ARMED && mc_tick && !power_down
    && !pd_hold && !kif.key_done && cnt != CNT_WIDTH'(`OWDT_CNT_TOP)
    |=> cnt == $past(cnt) + 1'b1)
    else $error("idle stopped counting");
  a_pin_oe_pair: assert property (@(posedge clk) disable iff (rst) // R08
    rst_pin_oe == rst_pin_o)
    else $error("reset pin enable differs from value");
  a_armed_flag: assert property (@(posedge clk) disable iff (rst) // R04
    wdt_armed == (state == OWDT_ARMED))
    else $error("armed flag differs from state");
  a_pulse_end: assert property (@(posedge clk) disable iff (rst) // R08 R16
    $fell(rst_pin_o) |-> state == OWDT_OFF)
    else $error("pulse end did not disarm");
endmodule : owdt_core

/* owdt_cpu_model.sv */
// CPU core model writing the key register
`timescale 1ns/1ns
`include "owdt_cfg.svh"
module owdt_cpu_model (
  // Clock
  input  wire logic       clk,
  // Register write port
  output logic            sfr_wr,
  output logic [7:0]      sfr_addr,
  output logic [7:0]      sfr_wdata
);
  initial begin
    sfr_wr = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
  end
  // One write, released lines show inverse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge clk);
    sfr_wr = 1'b0;
    sfr_addr = ~a;
    sfr_wdata = ~d;
  endtask : wr
  // Key pair, also used just before power-down
  task automatic service();
    wr(`OWDT_KEY_ADDR, `OWDT_KEY_FIRST);
    wr(`OWDT_KEY_ADDR, `OWDT_KEY_SECOND);
  endtask : service
endmodule : owdt_cpu_model

/* one_time_watchdog_reset_out_bench.sv */
// Self-checking bench for the one-time watchdog
`timescale 1ns/1ns
`include "owdt_cfg.svh"
module one_time_watchdog_reset_out_bench;
  localparam int W = 4;
  localparam int D = 2;
  localparam int P = 98;
  localparam int TOP = D * (2 ** W);
  logic       clk, rst, sfr_wr, idle_mode, power_down;
  logic       wake_int_low, idle_count_hold;
  logic [7:0] sfr_addr, sfr_wdata;
  logic       rst_pin_o, rst_pin_oe, wdt_armed;
  int         error_cnt = 0;
  int         n_tests = 0;
  owdt_cpu_model cpu_i (.clk(clk), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata));
  owdt_core #(.CNT_WIDTH(W), .MC_DIV(D), .PULSE_CYC(P)) owdt_core_i (
    .clk(clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .idle_mode(idle_mode), .power_down(power_down),
    .wake_int_low(wake_int_low), .idle_count_hold(idle_count_hold),
    .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .wdt_armed(wdt_armed));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  // No pulse for n cycles, arm state steady
  task automatic quiet(input int n, input logic arm);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      @(negedge clk);
      if (rst_pin_o !== 1'b0 || wdt_armed !== arm) bad = 1'b1;
    end
    chk(!bad, "unexpected reset or arm state");
  endtask : quiet
  // Overflow time, pulse length, disarm after
  task automatic fire(input int lo, input int hi);
    int n, w;
    n = 0;
    w = 0;
    while (rst_pin_o !== 1'b1 && n <= hi) begin
      @(negedge clk);
      n++;
    end
    chk(n >= lo && n <= hi, "overflow time");
    while (rst_pin_o === 1'b1 && rst_pin_oe === 1'b1 && w < P + 5) begin
      @(negedge clk);
      w++;
    end
    chk(w == P, "pulse length");
    chk(wdt_armed === 1'b0 && rst_pin_oe === 1'b0, "after pulse");
  endtask : fire
  task automatic tally_and_finish();
    $display("errors %0d, checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    idle_mode = 1'b0;
    power_down = 1'b0;
    wake_int_low = 1'b0;
    idle_count_hold = 1'b0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk(rst_pin_oe === 1'b0 && wdt_armed === 1'b0, "reset state");
    quiet(3 * TOP, 1'b0);
    cpu_i.wr(`OWDT_KEY_ADDR, `OWDT_KEY_SECOND);
    cpu_i.wr(`OWDT_KEY_ADDR, `OWDT_KEY_FIRST);
    cpu_i.wr(`OWDT_KEY_ADDR, 8'h55);
    cpu_i.wr(`OWDT_KEY_ADDR, `OWDT_KEY_SECOND);
    cpu_i.wr(8'ha5, `OWDT_KEY_FIRST);
    cpu_i.wr(`OWDT_KEY_ADDR, `OWDT_KEY_SECOND);
    quiet(10, 1'b0);
    cpu_i.wr(`OWDT_KEY_ADDR, `OWDT_KEY_FIRST);
    cpu_i.service();
    fire(TOP, TOP + 4);
    cpu_i.service();
    repeat (6) begin
      quiet(TOP / 2, 1'b1);
      cpu_i.wr(`OWDT_KEY_ADDR, 8'h00);
      cpu_i.service();
    end
    fire(TOP, TOP + 4);
    cpu_i.service();
    repeat (3) @(negedge clk);
    power_down = 1'b1;
    quiet(5 * TOP, 1'b1);
    wake_int_low = 1'b1;
    power_down = 1'b0;
    quiet(5 * TOP, 1'b1);
    wake_int_low = 1'b0;
    fire(TOP - 4, TOP + 4);
    idle_mode = 1'b1;
    cpu_i.service();
    fire(TOP, TOP + 4);
    idle_count_hold = 1'b1;
    cpu_i.service();
    quiet(5 * TOP, 1'b1);
    idle_mode = 1'b0;
    fire(TOP - 4, TOP + 4);
    cpu_i.service();
    quiet(TOP / 2, 1'b1);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    chk(wdt_armed === 1'b0 && rst_pin_o === 1'b0, "second reset");
    quiet(3 * TOP, 1'b0);
    tally_and_finish();
  end
endmodule : one_time_watchdog_reset_out_bench
